// ### shared/rtcc_pkg.sv
package rtcc_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BUSY_TIME_US  = 62500;
  localparam int unsigned BUSY_CYCLES   = BUSY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SUB_CLK_HZ    = 32768;
  // register byte offsets
  localparam logic [7:0] ADDR_RUNCTL = 8'h00;
  localparam logic [7:0] ADDR_IRQEN  = 8'h04;
  localparam logic [7:0] ADDR_CSR    = 8'h08;
  localparam logic [7:0] ADDR_SEC    = 8'h0C;
  localparam logic [7:0] ADDR_MIN    = 8'h10;
  localparam logic [7:0] ADDR_HOUR   = 8'h14;
  localparam logic [7:0] ADDR_WDAY   = 8'h18;
  localparam logic [7:0] ADDR_FLAG   = 8'h1C;
  // time_run_control fields
  localparam int RUN_BIT       = 7;
  localparam int FMT_BIT       = 6;
  localparam int AFTERNOON_BIT = 5;
  localparam int SRST_BIT      = 4;
  localparam int INT_BIT       = 3;
  localparam logic [7:0] RUNCTL_MASK  = 8'hF8;
  localparam logic [7:0] RUNCTL_RESET = 8'h00;
  // periodic_irq_enable fields
  localparam int EV_SEC     = 0;
  localparam int EV_WEEK    = 4;
  localparam int OVF_EN_BIT = 5;
  localparam logic [7:0] IRQEN_MASK  = 8'h3F;
  localparam logic [7:0] IRQEN_RESET = 8'h00;
  // clock_source_select fields
  localparam int CSR_CAL_BIT = 3;
  localparam int CSR_OUT_LO  = 5;
  localparam logic [7:0] CSR_MASK  = 8'h6F;
  localparam logic [7:0] CSR_RESET = 8'h08;
  // counters
  localparam int BUSY_BIT = 7;
  localparam logic [7:0] SEC_MAX    = 8'h59;
  localparam logic [7:0] HOUR12_MAX = 8'h11;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX   = 8'h06;
  localparam logic [7:0] SEC_MASK   = 8'h7F;
  localparam logic [7:0] HOUR_MASK  = 8'h3F;
  localparam logic [7:0] WDAY_MASK  = 8'h07;
  // flag register
  localparam int FLAG_CLK_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  typedef enum logic [0:0] {RTCC_IDLE, RTCC_BUSY} rtcc_state_type;
endpackage

// ### shared/rtcc_div_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtcc_div_if;
  logic [2:0] fr_sel;
  logic [1:0] out_sel;
  logic       fr_tick;
  logic       clk_div;
  modport top (output fr_sel, output out_sel, input fr_tick, input clk_div);
  modport div (input fr_sel, input out_sel, output fr_tick, output clk_div);
endinterface
`default_nettype wire

// ### hw/rtcc_div.sv
`timescale 1ns/1ns
`default_nettype none
module rtcc_div (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  rtcc_div_if.div   dif
);
  logic [12:0] cnt_r;
  logic        tick_r;
  logic        clk_div_r;

  // log2 of the counter prescale ratio per select code
  function automatic logic [3:0] ratio_log(input logic [2:0] sel);
    case (sel)
      3'h0:    ratio_log = 4'h3;
      3'h1:    ratio_log = 4'h5;
      3'h2:    ratio_log = 4'h7;
      3'h3:    ratio_log = 4'h8;
      3'h4:    ratio_log = 4'h9;
      3'h5:    ratio_log = 4'hB;
      3'h6:    ratio_log = 4'hC;
      default: ratio_log = 4'hD;
    endcase
  endfunction

  logic [13:0] low_mask;
  assign low_mask = (14'h0001 << ratio_log(dif.fr_sel)) - 14'h0001;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 13'h0000;
    end else begin
      cnt_r <= cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_r    <= 1'b0;
      clk_div_r <= 1'b0;
    end else begin
      tick_r    <= &({1'b0, cnt_r} | ~low_mask);
      clk_div_r <= cnt_r[{1'b0, dif.out_sel} + 3'h1];
    end
  end

  assign dif.fr_tick = tick_r;
  assign dif.clk_div = clk_div_r;
endmodule
`default_nettype wire

// ### hw/rtcc_top.sv
// Functional notes
// (R1) run bit starts and stops time counting
// (R2) format bit zero: hours count 0 to 11
// (R3) format bit one: hours count 0 to 23
// (R4) afternoon flag shows half of day
// (R5) soft reset clears all but source select; the flag register keeps its value
// (R6) software writes soft reset back to zero
// (R7) int bit: fire during or after busy
// (R8) reserved bits read as zero
// (R9) enabled periodic event sets clock flag
// (R10) overflow enable gates counter overflow interrupt
// (R11) five bits enable week to second events
// (R12) non-calendar source gives 8-bit free counter
// (R13) seconds register reads counter in that mode
// (R14) run bit starts and stops free counter
// (R15) source codes pick prescale or calendar
// (R16) output select picks divided clock for pin
// (R17) clock out only in active or sleep
// (R18) busy bit high while counters update
// (R19) busy clears after 62.5 ms
// (R20) software clears clock flag by writing zero
// (R21) week on weekday wrap, day on increment
// (R22) 12h wrap toggles afternoon, day on afternoon end
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rtcc_top #(
  parameter int unsigned BUSY_CYC = rtcc_pkg::BUSY_CYCLES,
  parameter int unsigned SUB_DIV  = rtcc_pkg::SUB_CLK_HZ
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sub_clk_i,
  input  wire logic        clkout_pin_en_i,
  input  wire logic        pwr_active_i,
  output logic             divided_clock_out_o,
  output logic             clock_irq_flag_o,
  output logic             ovf_irq_flag_o,
  output logic             update_pending_o
);
  import rtcc_pkg::*;

  rtcc_div_if dif ();

  rtcc_div u_div (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .dif    (dif)
  );

  ////////////////////////////////////////////////////////////////
  logic [7:0]     runctl_r;
  logic [7:0]     irqen_r;
  logic [7:0]     csr_r;
  logic [7:0]     sec_r;
  logic [7:0]     min_r;
  logic [7:0]     hour_r;
  logic [7:0]     wday_r;
  logic [7:0]     fr_cnt_r;
  logic [1:0]     flag_r;
  rtcc_state_type state_r;
  logic [31:0]    busy_cnt_r;
  logic [31:0]    sub_cnt_r;
  logic [2:0]     sub_sync_r;
  logic           pready_r;
  logic           pslverr_r;
  logic [31:0]    prdata_r;
  logic           clkout_r;

  logic srst;
  logic run;
  logic cal;
  logic setup;
  logic wr;
  logic sub_edge;
  logic sec_tick;
  logic busy_start;
  logic upd;
  logic [4:0] evt;
  logic [8:0] s_n;
  logic [8:0] m_n;
  logic [8:0] h_n;
  logic [8:0] w_n;
  logic       fire;
  logic       fr_ovf;

  assign srst  = runctl_r[SRST_BIT];
  assign run   = runctl_r[RUN_BIT];
  assign cal   = csr_r[CSR_CAL_BIT];
  assign setup = psel_i & ~penable_i;
  assign wr    = psel_i & penable_i & pwrite_i & pready_r;

  function automatic logic wr_to(input logic w, input logic [7:0] a, input logic [7:0] off);
    wr_to = w && (a == off);
  endfunction

  // returns {wrap, next} of a bcd count that rolls over after maxv
  function automatic logic [8:0] bcd_next(input logic [7:0] v, input logic [7:0] maxv);
    logic [8:0] r;
    r = 9'h000;
    if (v >= maxv) begin
      r = {1'b1, 8'h00};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // sub clock arrives from a pin: two flops before the edge detector
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sub_sync_r <= 3'h0;
    end else begin
      sub_sync_r <= {sub_sync_r[1:0], sub_clk_i};
    end
  end
  assign sub_edge = sub_sync_r[1] & ~sub_sync_r[2];

  // one second prescaler, held while stopped and cleared in counter mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sub_cnt_r <= 32'h0000_0000;
    end else if (srst || !cal) begin  // R5 R12
      sub_cnt_r <= 32'h0000_0000;
    end else if (run && sub_edge) begin  // R1
      sub_cnt_r <= (sub_cnt_r == SUB_DIV - 1) ? 32'h0000_0000 : sub_cnt_r + 32'h0000_0001;
    end
  end
  assign sec_tick   = run && cal && sub_edge && (sub_cnt_r == SUB_DIV - 1);
  assign busy_start = sec_tick && (state_r == RTCC_IDLE);
  assign upd        = (state_r == RTCC_BUSY) && (busy_cnt_r == BUSY_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // busy window: counters change only at its end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r    <= RTCC_IDLE;
      busy_cnt_r <= 32'h0000_0000;
    end else if (srst) begin  // R5
      state_r    <= RTCC_IDLE;
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        RTCC_IDLE: begin
          busy_cnt_r <= 32'h0000_0000;
          if (busy_start) begin
            state_r <= RTCC_BUSY;  // R18
          end
        end
        RTCC_BUSY: begin
          busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
          if (upd) begin
            state_r <= RTCC_IDLE;  // R19
          end
        end
        default: state_r <= RTCC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // carries are the same at busy start and end since counts hold
  always_comb begin
    s_n = bcd_next(sec_r, SEC_MAX);
    m_n = bcd_next(min_r, SEC_MAX);
    h_n = bcd_next(hour_r, runctl_r[FMT_BIT] ? HOUR24_MAX : HOUR12_MAX);  // R2 R3
    w_n = bcd_next(wday_r, WDAY_MAX);
    evt[0] = 1'b1;
    evt[1] = s_n[8];
    evt[2] = s_n[8] & m_n[8];
    evt[3] = evt[2] & h_n[8] & (runctl_r[FMT_BIT] | runctl_r[AFTERNOON_BIT]);  // R21 R22
    evt[4] = evt[3] & w_n[8];  // R21
  end

  // second up to week counters; software write wins over an update
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_r  <= 8'h00;
      min_r  <= 8'h00;
      hour_r <= 8'h00;
      wday_r <= 8'h00;
    end else if (srst) begin  // R5
      sec_r  <= 8'h00;
      min_r  <= 8'h00;
      hour_r <= 8'h00;
      wday_r <= 8'h00;
    end else begin
      if (wr_to(wr, paddr_i, ADDR_SEC)) begin
        sec_r <= pwdata_i[7:0] & SEC_MASK;
      end else if (upd) begin
        sec_r <= s_n[7:0];
      end
      if (wr_to(wr, paddr_i, ADDR_MIN)) begin
        min_r <= pwdata_i[7:0] & SEC_MASK;
      end else if (upd && evt[1]) begin
        min_r <= m_n[7:0];
      end
      if (wr_to(wr, paddr_i, ADDR_HOUR)) begin
        hour_r <= pwdata_i[7:0] & HOUR_MASK;
      end else if (upd && evt[2]) begin
        hour_r <= h_n[7:0];  // R2 R3
      end
      if (wr_to(wr, paddr_i, ADDR_WDAY)) begin
        wday_r <= pwdata_i[7:0] & WDAY_MASK;
      end else if (upd && evt[3]) begin
        wday_r <= w_n[7:0];  // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control registers; soft reset spares its own bit and the source select
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      runctl_r <= RUNCTL_RESET;
    end else begin
      if (wr_to(wr, paddr_i, ADDR_RUNCTL)) begin
        runctl_r[SRST_BIT] <= pwdata_i[SRST_BIT];  // R6
      end
      if (srst) begin
        runctl_r[RUN_BIT:AFTERNOON_BIT] <= 3'h0;  // R5
        runctl_r[INT_BIT]               <= 1'b0;
      end else if (wr_to(wr, paddr_i, ADDR_RUNCTL)) begin
        runctl_r[RUN_BIT:AFTERNOON_BIT] <= pwdata_i[RUN_BIT:AFTERNOON_BIT];  // R1 R4
        runctl_r[INT_BIT]               <= pwdata_i[INT_BIT];  // R7
      end else if (upd && evt[2] && h_n[8] && !runctl_r[FMT_BIT]) begin
        runctl_r[AFTERNOON_BIT] <= ~runctl_r[AFTERNOON_BIT];  // R4 R22
      end
      runctl_r[2:0] <= 3'h0;  // R8
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irqen_r <= IRQEN_RESET;
    end else if (srst) begin  // R5
      irqen_r <= IRQEN_RESET;
    end else if (wr_to(wr, paddr_i, ADDR_IRQEN)) begin
      irqen_r <= pwdata_i[7:0] & IRQEN_MASK;  // R8 R10 R11
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csr_r <= CSR_RESET;
    end else if (wr_to(wr, paddr_i, ADDR_CSR)) begin
      csr_r <= pwdata_i[7:0] & CSR_MASK;  // R8 R15
    end
  end

  ////////////////////////////////////////////////////////////////
  // free-running counter mode
  assign dif.fr_sel  = csr_r[2:0];  // R15
  assign dif.out_sel = csr_r[CSR_OUT_LO+1:CSR_OUT_LO];  // R16
  assign fr_ovf = run && !cal && dif.fr_tick && (fr_cnt_r == 8'hFF);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fr_cnt_r <= 8'h00;
    end else if (srst) begin  // R5
      fr_cnt_r <= 8'h00;
    end else if (!cal && wr_to(wr, paddr_i, ADDR_SEC)) begin
      fr_cnt_r <= pwdata_i[7:0];
    end else if (run && !cal && dif.fr_tick) begin  // R12 R14
      fr_cnt_r <= fr_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags: writing zero clears, a same-cycle event wins
  assign fire = (runctl_r[INT_BIT] ? upd : busy_start)  // R7
                && |(evt & irqen_r[EV_WEEK:EV_SEC]);  // R9 R11

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= 2'h0;
    end else begin
      if (fire) begin
        flag_r[FLAG_CLK_BIT] <= 1'b1;  // R9
      end else if (wr_to(wr, paddr_i, ADDR_FLAG) && !pwdata_i[FLAG_CLK_BIT]) begin
        flag_r[FLAG_CLK_BIT] <= 1'b0;  // R20
      end
      if (fr_ovf && irqen_r[OVF_EN_BIT]) begin
        flag_r[FLAG_OVF_BIT] <= 1'b1;  // R10
      end else if (wr_to(wr, paddr_i, ADDR_FLAG) && !pwdata_i[FLAG_OVF_BIT]) begin
        flag_r[FLAG_OVF_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave: no wait state, read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (setup) begin
        case (paddr_i)
          ADDR_RUNCTL: prdata_r[7:0] <= runctl_r;
          ADDR_IRQEN:  prdata_r[7:0] <= irqen_r;
          ADDR_CSR:    prdata_r[7:0] <= csr_r;
          ADDR_SEC:    prdata_r[7:0] <= cal ? {update_pending_o, sec_r[6:0]} : fr_cnt_r;  // R13 R18
          ADDR_MIN:    prdata_r[7:0] <= {update_pending_o, min_r[6:0]};
          ADDR_HOUR:   prdata_r[7:0] <= {update_pending_o, hour_r[6:0]};
          ADDR_WDAY:   prdata_r[7:0] <= {update_pending_o, wday_r[6:0]};
          ADDR_FLAG:   prdata_r[1:0] <= flag_r;
          default:     pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // clock output only while enabled on the port and in active or sleep
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clkout_r <= 1'b0;
    end else begin
      clkout_r <= clkout_pin_en_i && pwr_active_i && dif.clk_div;  // R16 R17
    end
  end

  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign divided_clock_out_o = clkout_r;
  assign clock_irq_flag_o    = flag_r[FLAG_CLK_BIT];
  assign ovf_irq_flag_o      = flag_r[FLAG_OVF_BIT];
  assign update_pending_o    = (state_r == RTCC_BUSY);

  ////////////////////////////////////////////////////////////////
  int unsigned busy_len_h;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_len_h <= 0;
    end else begin
      busy_len_h <= update_pending_o ? busy_len_h + 1 : 0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_run_stop;
    (!run && !srst && state_r == RTCC_IDLE && !wr) |=> $stable(sec_r);
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("seconds moved while stopped"); // R1

  property p_h12;
    (upd && !srst && !runctl_r[FMT_BIT] && !wr) |=> (hour_r <= HOUR12_MAX);
  endproperty
  a_h12: assert property (p_h12) else $error("12h hours out of range"); // R2

  property p_h24;
    (upd && !srst && runctl_r[FMT_BIT] && !wr && hour_r == HOUR24_MAX && evt[2]) |=> (hour_r == 8'h00);
  endproperty
  a_h24: assert property (p_h24) else $error("24h hours did not wrap at 23"); // R3

  property p_half_toggle;
    (upd && !srst && !wr && !runctl_r[FMT_BIT] && evt[2] && hour_r == HOUR12_MAX)
      |=> (runctl_r[AFTERNOON_BIT] != $past(runctl_r[AFTERNOON_BIT])) && (hour_r == 8'h00);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("afternoon flag not toggled"); // R22

  property p_srst;
    // source select stays writable during soft reset
    (srst && !wr_to(wr, paddr_i, ADDR_CSR))
      |=> (sec_r == 8'h00) && (irqen_r == 8'h00) && !update_pending_o && $stable(csr_r);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset incomplete"); // R5

  property p_busy_len;
    ($fell(update_pending_o) && !$past(srst)) |-> (busy_len_h == BUSY_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy window length wrong"); // R19

  property p_fire_after;
    (upd && !srst && runctl_r[INT_BIT] && |(evt & irqen_r[4:0])) |=> clock_irq_flag_o;
  endproperty
  a_fire_after: assert property (p_fire_after) else $error("flag not set after busy"); // R9

  property p_fire_during;
    (busy_start && !srst && !runctl_r[INT_BIT] && |(evt & irqen_r[4:0])) |=> (clock_irq_flag_o && update_pending_o);
  endproperty
  a_fire_during: assert property (p_fire_during) else $error("flag not set during busy"); // R7

  property p_ovf;
    (fr_ovf && !srst && !wr && irqen_r[OVF_EN_BIT]) |=> ovf_irq_flag_o && (fr_cnt_r == 8'h00);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing"); // R10

  property p_fr_read;
    (setup && paddr_i == ADDR_SEC && !cal) |=> (prdata_o[7:0] == $past(fr_cnt_r)) && pready_o;
  endproperty
  a_fr_read: assert property (p_fr_read) else $error("counter read wrong"); // R13

  property p_clkout_off;
    !pwr_active_i |=> !divided_clock_out_o;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock out in low power"); // R17

  c_update: cover property (upd ##1 !update_pending_o);
  c_flag:   cover property (fire ##1 clock_irq_flag_o);
  c_ovf:    cover property (fr_ovf && irqen_r[OVF_EN_BIT]);
  c_srst:   cover property ($rose(srst) ##[1:20] $fell(srst));
endmodule
`default_nettype wire

// ### dv/test_rtc_control_and_clock_select.sv
`timescale 1ns/1ns
`default_nettype none
module test_rtc_control_and_clock_select;
  import rtcc_pkg::*;
  logic        clk_i     = 1'h0;
  logic        rstn_i    = 1'h0;
  logic [7:0]  paddr_i   = 8'h00;
  logic        psel_i    = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i  = 1'h0;
  logic [31:0] pwdata_i  = 32'h0;
  logic        sub_clk_i = 1'h0;
  logic        pin_en    = 1'h1;
  logic        pwr_on    = 1'h1;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        dco;
  logic        clk_flag;
  logic        ovf_flag;
  logic        busy;
  logic [3:0]  sub_cnt   = 4'h0;
  logic [31:0] rd;
  logic        err;
  logic        hi;
  int          busy_len  = 0;
  int          last_len  = 0;
  int          mismatches = 0;
  int          check_count = 0;
  int          g;
  int          shift_tab[8] = '{3, 5, 7, 8, 9, 11, 12, 13};

  rtcc_top #(.BUSY_CYC(20), .SUB_DIV(4)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sub_clk_i(sub_clk_i), .clkout_pin_en_i(pin_en), .pwr_active_i(pwr_on),
    .divided_clock_out_o(dco), .clock_irq_flag_o(clk_flag),
    .ovf_irq_flag_o(ovf_flag), .update_pending_o(busy));

  ////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // sub clock period of 20 cycles leaves room to read between updates
  always @(posedge clk_i) begin
    sub_cnt <= (sub_cnt == 4'h9) ? 4'h0 : sub_cnt + 4'h1;
    if (sub_cnt == 4'h9) sub_clk_i <= ~sub_clk_i;
    busy_len <= (busy === 1'h1) ? busy_len + 1 : 0;
    if (busy !== 1'h1 && busy_len != 0) last_len <= busy_len;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (pready_o !== 1'h1) mismatches++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask

  // one update of the calendar from a preset time, then soft reset
  task automatic cal(input logic [7:0] c, s, m, h, w, en, es, em, eh, ew, ec, input logic ef);
    int n;
    n = 0;
    wr(ADDR_RUNCTL, c & 8'h7F);
    wr(ADDR_SEC, s);
    wr(ADDR_MIN, m);
    wr(ADDR_HOUR, h);
    wr(ADDR_WDAY, w);
    wr(ADDR_IRQEN, en);
    wr(ADDR_FLAG, 8'h00);
    wr(ADDR_RUNCTL, c);
    while (busy !== 1'h1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    rc(ADDR_MIN, m | 8'h80);
    check({31'h0, clk_flag}, {31'h0, ef & ~c[INT_BIT]});
    while (busy !== 1'h0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    check(last_len, 20);
    check({31'h0, clk_flag}, {31'h0, ef});
    rc(ADDR_SEC, es);
    rc(ADDR_MIN, em);
    rc(ADDR_HOUR, eh);
    rc(ADDR_WDAY, ew);
    rc(ADDR_RUNCTL, ec);
    wr(ADDR_RUNCTL, 8'h10);
    wr(ADDR_RUNCTL, 8'h00);
    $display("Test calendar case done");
  endtask

  task automatic gated(output logic h);
    repeat (3) @(posedge clk_i);
    h = 1'h0;
    repeat (64) begin
      @(posedge clk_i);
      h = h | dco;
    end
  endtask

  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #1200000;
    mismatches++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'h1;
    rc(ADDR_RUNCTL, 8'h00);
    rc(ADDR_IRQEN, 8'h00);
    rc(ADDR_CSR, 8'h08);
    apb(1'h0, 8'h20, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    wr(ADDR_RUNCTL, 8'hEF);
    rc(ADDR_RUNCTL, 8'hE8);
    wr(ADDR_IRQEN, 8'hFF);
    rc(ADDR_IRQEN, 8'h3F);
    wr(ADDR_CSR, 8'hFF);
    rc(ADDR_CSR, 8'h6F);
    wr(ADDR_RUNCTL, 8'h10);
    rc(ADDR_RUNCTL, 8'h10);
    rc(ADDR_IRQEN, 8'h00);
    rc(ADDR_CSR, 8'h6F);
    wr(ADDR_RUNCTL, 8'h18);
    rc(ADDR_RUNCTL, 8'h10);
    wr(ADDR_RUNCTL, 8'h00);
    rc(ADDR_RUNCTL, 8'h00);
    wr(ADDR_CSR, 8'h08);
    $display("Test registers done");
    cal(8'hC0, 8'h59, 8'h59, 8'h23, 8'h06, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 1'h1);
    cal(8'hC8, 8'h10, 8'h00, 8'h00, 8'h05, 8'h04, 8'h11, 8'h00, 8'h00, 8'h05, 8'hC8, 1'h0);
    cal(8'hA8, 8'h59, 8'h59, 8'h11, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h03, 8'h88, 1'h1);
    cal(8'h80, 8'h59, 8'h59, 8'h11, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h02, 8'hA0, 1'h0);
    cal(8'hC8, 8'h59, 8'h59, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01, 8'hC8, 1'h1);
    cal(8'hC0, 8'h59, 8'h59, 8'h23, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h06, 8'hC0, 1'h0);
    cal(8'hC0, 8'h59, 8'h59, 8'h11, 8'h03, 8'h04, 8'h00, 8'h00, 8'h12, 8'h03, 8'hC0, 1'h1);
    cal(8'hC0, 8'h09, 8'h00, 8'h00, 8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'hC0, 1'h1);
    rc(ADDR_FLAG, 8'h01);
    wr(ADDR_FLAG, 8'h02);
    rc(ADDR_FLAG, 8'h00);
    wr(ADDR_RUNCTL, 8'h40);
    wr(ADDR_SEC, 8'h20);
    repeat (200) @(posedge clk_i);
    rc(ADDR_SEC, 8'h20);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CSR, 8'h08 | 8'(k << 5));
      // old select still reaches the pin for a few cycles
      repeat (4) @(posedge clk_i);
      g = 0;
      for (int i = 0; i < 4; i++) begin
        for (int n = 0; n < 200 && dco !== logic'(i[0]); n++) begin
          @(posedge clk_i);
          if (i > 1) g++;
        end
      end
      check(g, 4 << k);
    end
    pin_en <= 1'h0;
    gated(hi);
    check({31'h0, hi}, 32'h0);
    pin_en <= 1'h1;
    pwr_on <= 1'h0;
    gated(hi);
    check({31'h0, hi}, 32'h0);
    pwr_on <= 1'h1;
    $display("Test clock output done");
    // a window of 2.5 prescale periods holds 2 or 3 ticks, whatever the phase
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CSR, 8'(k));
      wr(ADDR_SEC, 8'h00);
      wr(ADDR_RUNCTL, 8'h80);
      repeat ((5 << shift_tab[k]) / 2 - 3) @(posedge clk_i);
      wr(ADDR_RUNCTL, 8'h00);
      apb(1'h0, ADDR_SEC, 8'h00);
      check({31'h0, rd === 32'h2 || rd === 32'h3}, 32'h1);
    end
    wr(ADDR_SEC, 8'h33);
    repeat (40) @(posedge clk_i);
    rc(ADDR_SEC, 8'h33);
    wr(ADDR_CSR, 8'h00);
    wr(ADDR_SEC, 8'hFE);
    wr(ADDR_RUNCTL, 8'h80);
    repeat (60) @(posedge clk_i);
    check({31'h0, ovf_flag}, 32'h0);
    wr(ADDR_RUNCTL, 8'h00);
    wr(ADDR_IRQEN, 8'h20);
    wr(ADDR_SEC, 8'hFE);
    wr(ADDR_RUNCTL, 8'h80);
    for (int n = 0; n < 100 && ovf_flag !== 1'h1; n++) @(posedge clk_i);
    check({31'h0, ovf_flag}, 32'h1);
    $display("Test free counter done");
    results();
  end
endmodule
`default_nettype wire
